/* core/bram_pkg.sv */
package bram_pkg;

    // ------------------------------------------------------------
    // array geometry
    // ------------------------------------------------------------
    localparam int UNITS = 8192;
    localparam int UNIT_W = 9;
    localparam int ADDR_W = 14;
    localparam int PTR_W = 15;
    localparam int DATA_W = 512;
    localparam int LANES = 64;
    localparam int PAR_LANES = 16;
    localparam int MODE_W = 4;

    // ------------------------------------------------------------
    // organization codes (depth x width)
    // ------------------------------------------------------------
    localparam logic [3:0] MODE_512X144 = 4'h0;
    localparam logic [3:0] MODE_128X512 = 4'h1;
    localparam logic [3:0] MODE_1024X72 = 4'h2;
    localparam logic [3:0] MODE_1024X64 = 4'h3;
    localparam logic [3:0] MODE_2048X36 = 4'h4;
    localparam logic [3:0] MODE_2048X32 = 4'h5;
    localparam logic [3:0] MODE_4096X18 = 4'h6;
    localparam logic [3:0] MODE_4096X16 = 4'h7;
    localparam logic [3:0] MODE_8192X9 = 4'h8;
    localparam logic [3:0] MODE_8192X8 = 4'h9;
    localparam logic [3:0] MODE_16384X4 = 4'hA;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [14:0] PTR_RESET = 15'h0000;

    // unknown codes fall back to the widest parity organization
    function automatic logic [3:0] mode_fix(input logic [3:0] m);
        return (m > MODE_16384X4) ? MODE_512X144 : m;
    endfunction

    // log2 of 9-bit (or 8-bit) units per word
    function automatic logic [2:0] mode_k(input logic [3:0] m);
        logic [2:0] k;
        k = 3'h0;
        case (m)
            MODE_512X144: k = 3'h4;
            MODE_128X512: k = 3'h6;
            MODE_1024X72, MODE_1024X64: k = 3'h3;
            MODE_2048X36, MODE_2048X32: k = 3'h2;
            MODE_4096X18, MODE_4096X16: k = 3'h1;
            default: k = 3'h0;
        endcase
        return k;
    endfunction

    // words per organization
    function automatic logic [14:0] mode_depth(input logic [3:0] m);
        logic [14:0] d;
        d = 15'h0200;
        case (m)
            MODE_512X144: d = 15'h0200;
            MODE_128X512: d = 15'h0080;
            MODE_1024X72, MODE_1024X64: d = 15'h0400;
            MODE_2048X36, MODE_2048X32: d = 15'h0800;
            MODE_4096X18, MODE_4096X16: d = 15'h1000;
            MODE_8192X9, MODE_8192X8: d = 15'h2000;
            default: d = 15'h4000;
        endcase
        return d;
    endfunction

    // widths that are multiples of nine carry the ninth bit
    function automatic logic mode_par(input logic [3:0] m);
        return (m == MODE_512X144) || (m == MODE_1024X72) ||
            (m == MODE_2048X36) || (m == MODE_4096X18) ||
            (m == MODE_8192X9);
    endfunction

    function automatic logic [14:0] g2b(input logic [14:0] g);
        logic [14:0] b;
        b = g;
        for (int i = 13; i >= 0; i--)
        begin
            b[i] = b[i + 1] ^ g[i];
        end
        return b;
    endfunction

endpackage

/* core/ram_read_if.sv */
`timescale 1ns/1ps
interface ram_read_if;
    logic [13:0] rd_addr;
    logic [511:0] rd_word;
    logic [14:0] wr_gray;
    logic [14:0] rd_gray;
    logic [3:0] rd_mode;
    logic fifo_mode;
    logic srst;

    modport array_side(
        input rd_addr,
        input rd_gray,
        output rd_word,
        output wr_gray,
        output rd_mode,
        output fifo_mode,
        output srst
    );

    modport read_side(
        output rd_addr,
        output rd_gray,
        input rd_word,
        input wr_gray,
        input rd_mode,
        input fifo_mode,
        input srst
    );
endinterface

/* core/read_port.sv */
`timescale 1ns/1ps
module read_port (
    // read clock
    input wire logic rd_clk,
    // user read request
    input wire logic rd_en,
    input wire logic [13:0] rd_addr_in,
    // registered answer
    output logic [511:0] rd_data,
    output logic rd_valid,
    output logic rd_empty,
    // array side
    ram_read_if.read_side rif
);

    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        logic [3:0] rd_mode;
        logic fifo;
        logic [14:0] wg_s1;
        logic [14:0] wg_s2;
        logic [14:0] rbin;
        logic [14:0] rgray;
        logic [511:0] data;
        logic valid;
        logic empty;
    } rd_state_t;

    rd_state_t st_r;
    rd_state_t st_nxt;
    logic fire;
    logic [14:0] mask;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        mask = bram_pkg::mode_depth(st_r.rd_mode) - 15'h0001;
        // empty flag lives here only; writers see full, never empty
        fire = rd_en && !(st_r.fifo && st_r.empty);
        st_nxt.rst_s1 = rif.srst;
        st_nxt.rst_s2 = st_r.rst_s1;
        st_nxt.wg_s1 = rif.wr_gray;
        st_nxt.wg_s2 = st_r.wg_s1;
        st_nxt.valid = fire;
        if (fire)
        begin
            st_nxt.data = rif.rd_word;
        end
        if (fire && st_r.fifo)
        begin
            st_nxt.rbin = st_r.rbin + 15'h0001;
            st_nxt.rgray = st_nxt.rbin ^ (st_nxt.rbin >> 1);
        end
        st_nxt.empty = st_r.fifo &&
            (st_nxt.rbin == bram_pkg::g2b(st_r.wg_s2));
        // config is static while reset is held, so it is safe to take
        if (st_r.rst_s2)
        begin
            st_nxt.rd_mode = rif.rd_mode;
            st_nxt.fifo = rif.fifo_mode;
            st_nxt.rbin = bram_pkg::PTR_RESET;
            st_nxt.rgray = bram_pkg::PTR_RESET;
            st_nxt.data = '0;
            st_nxt.valid = 1'b0;
            st_nxt.empty = rif.fifo_mode;
        end
    end

    always_ff @(posedge rd_clk)
    begin
        st_r <= st_nxt;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rif.rd_addr = st_r.fifo ? (st_r.rbin[13:0] & mask[13:0])
        : rd_addr_in;
    assign rif.rd_gray = st_r.rgray;
    assign rd_data = st_r.data;
    assign rd_valid = st_r.valid;
    assign rd_empty = st_r.empty;

endmodule

/* core/dual_clock_block_ram.sv */
`timescale 1ns/1ps
module dual_clock_block_ram (
    // write clock and reset
    input wire logic CORE_CLK,
    input wire logic SRST,
    // read clock
    input wire logic RD_CLK,
    // organization, taken while SRST is high
    input wire logic [3:0] WR_MODE,
    input wire logic [3:0] RD_MODE,
    input wire logic ROM_MODE,
    input wire logic FIFO_MODE,
    // write port
    input wire logic WR_EN,
    input wire logic [13:0] WR_ADDR,
    input wire logic [511:0] WR_DATA,
    output logic WR_FULL,
    // read port
    input wire logic RD_EN,
    input wire logic [13:0] RD_ADDR,
    output logic [511:0] RD_DATA,
    output logic RD_VALID,
    output logic RD_EMPTY
);

    // ------------------------------------------------------------
    // write side record
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] wr_mode;
        logic [3:0] rd_mode;
        logic rom;
        logic fifo;
        logic [14:0] wbin;
        logic [14:0] wgray;
        logic [14:0] rg_s1;
        logic [14:0] rg_s2;
        logic full;
    } wr_state_t;

    wr_state_t st_r;
    wr_state_t st_nxt;
    ram_read_if rif();

    // the array is kept apart from the state record: it is far too
    // wide to copy through a combinational process every cycle
    logic [8:0] mem [0:8191];
    logic wr_fire;
    logic [13:0] wr_addr_eff;
    logic [14:0] wmask;
    logic [14:0] used;
    logic [2:0] wk;
    logic wpar;
    logic wnib;
    logic [12:0] wbase;
    logic [2:0] rk;
    logic rpar;
    logic rnib;
    logic [12:0] rbase;
    logic [8:0] lane [0:63];
    logic [511:0] rd_word_c;

    // ------------------------------------------------------------
    // write side state
    // ------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        wk = bram_pkg::mode_k(st_r.wr_mode);
        wpar = bram_pkg::mode_par(st_r.wr_mode);
        wnib = st_r.wr_mode == bram_pkg::MODE_16384X4;
        wmask = bram_pkg::mode_depth(st_r.wr_mode) - 15'h0001;
        wr_addr_eff = st_r.fifo ? (st_r.wbin[13:0] & wmask[13:0])
            : WR_ADDR;
        wr_fire = WR_EN && !SRST && !st_r.rom &&
            !(st_r.fifo && st_r.full);
        wbase = wnib ? wr_addr_eff[13:1] : 13'(wr_addr_eff << wk);
        st_nxt.rg_s1 = rif.rd_gray;
        st_nxt.rg_s2 = st_r.rg_s1;
        if (wr_fire && st_r.fifo)
        begin
            st_nxt.wbin = st_r.wbin + 15'h0001;
            st_nxt.wgray = st_nxt.wbin ^ (st_nxt.wbin >> 1);
        end
        // full is pessimistic by the sync delay, never optimistic
        used = st_nxt.wbin - bram_pkg::g2b(st_r.rg_s2);
        st_nxt.full = st_r.fifo &&
            (used >= bram_pkg::mode_depth(st_r.wr_mode));
        if (SRST)
        begin
            st_nxt.wr_mode = bram_pkg::mode_fix(WR_MODE);
            st_nxt.rd_mode = bram_pkg::mode_fix(RD_MODE);
            st_nxt.rom = ROM_MODE;
            st_nxt.fifo = FIFO_MODE;
            st_nxt.wbin = bram_pkg::PTR_RESET;
            st_nxt.wgray = bram_pkg::PTR_RESET;
            // a read pointer left over from an earlier run must not
            // leak into the first full decision
            st_nxt.rg_s1 = bram_pkg::PTR_RESET;
            st_nxt.rg_s2 = bram_pkg::PTR_RESET;
            st_nxt.full = 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        st_r <= st_nxt;
    end

    // ------------------------------------------------------------
    // array write, write port only
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK)
    begin
        if (wr_fire)
        begin
            if (wnib)
            begin
                // bit 8 of a nibble unit is never written
                if (wr_addr_eff[0])
                    mem[wbase][7:4] <= WR_DATA[3:0];
                else
                    mem[wbase][3:0] <= WR_DATA[3:0];
            end
            else if (wpar)
            begin
                for (int i = 0; i < bram_pkg::PAR_LANES; i++)
                begin
                    if (i < (1 << wk))
                        mem[wbase + 13'(i)] <= WR_DATA[i * 9 +: 9];
                end
            end
            else
            begin
                for (int i = 0; i < bram_pkg::LANES; i++)
                begin
                    if (i < (1 << wk))
                        mem[wbase + 13'(i)] <= {1'b0, WR_DATA[i * 8 +: 8]};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // array read lanes, registered in the read domain
    // ------------------------------------------------------------
    assign rk = bram_pkg::mode_k(st_r.rd_mode);
    assign rpar = bram_pkg::mode_par(st_r.rd_mode);
    assign rnib = st_r.rd_mode == bram_pkg::MODE_16384X4;
    assign rbase = rnib ? rif.rd_addr[13:1] : 13'(rif.rd_addr << rk);

    // all lanes read every cycle; the mux below keeps what the mode uses
    for (genvar g = 0; g < bram_pkg::LANES; g++)
    begin : g_lane
        assign lane[g] = mem[rbase + 13'(g)];
    end

    always_comb
    begin
        rd_word_c = '0;
        if (rnib)
        begin
            rd_word_c[3:0] = rif.rd_addr[0] ? lane[0][7:4] : lane[0][3:0];
        end
        else if (rpar)
        begin
            for (int i = 0; i < bram_pkg::PAR_LANES; i++)
            begin
                if (i < (1 << rk))
                    rd_word_c[i * 9 +: 9] = lane[i];
            end
        end
        else
        begin
            for (int i = 0; i < bram_pkg::LANES; i++)
            begin
                if (i < (1 << rk))
                    rd_word_c[i * 8 +: 8] = lane[i][7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // handed to the read port
    // ------------------------------------------------------------
    assign rif.rd_word = rd_word_c;
    assign rif.wr_gray = st_r.wgray;
    assign rif.rd_mode = st_r.rd_mode;
    assign rif.fifo_mode = st_r.fifo;
    assign rif.srst = SRST;

    // ------------------------------------------------------------
    // read port, own clock domain
    // ------------------------------------------------------------
    read_port u_read (
        .rd_clk(RD_CLK),
        .rd_en(RD_EN),
        .rd_addr_in(RD_ADDR),
        .rd_data(RD_DATA),
        .rd_valid(RD_VALID),
        .rd_empty(RD_EMPTY),
        .rif(rif.read_side)
    );

    // ------------------------------------------------------------
    // write side status
    // ------------------------------------------------------------
    // full lives in this domain only; the read port resynchronizes the write pointer, not full
    assign WR_FULL = st_r.full;

endmodule

/* sim/bram_chk.sv */
`timescale 1ns/1ps
module bram_chk (
    // clocks and reset
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire logic RD_CLK,
    // static modes
    input wire logic [3:0] RD_MODE,
    input wire logic FIFO_MODE,
    // status and read port
    input wire logic WR_FULL,
    input wire logic RD_EN,
    input wire logic [511:0] RD_DATA,
    input wire logic RD_VALID,
    input wire logic RD_EMPTY
);
    // ----
    // read acceptance
    // ----
    sequence s_taken;
        RD_EN && (!FIFO_MODE || !RD_EMPTY);
    endsequence
    sequence s_refused;
        RD_EN && FIFO_MODE && RD_EMPTY;
    endsequence

    a_read_answer: assert property (@(posedge RD_CLK) disable iff (SRST)
        s_taken |=> RD_VALID) else $error("read not answered");
    a_no_spurious: assert property (@(posedge RD_CLK) disable iff (SRST)
        !RD_EN |=> !RD_VALID) else $error("valid without request");
    a_data_hold: assert property (@(posedge RD_CLK) disable iff (SRST)
        !RD_VALID |-> $stable(RD_DATA)) else $error("data moved");
    a_refuse_empty: assert property (@(posedge RD_CLK) disable iff (SRST)
        s_refused |=> !RD_VALID) else $error("read while empty");
    a_empty_ram: assert property (@(posedge RD_CLK) disable iff (SRST)
        !FIFO_MODE |-> !RD_EMPTY) else $error("empty outside fifo");
    a_empty_rst: assert property (@(posedge RD_CLK)
        $fell(SRST) && FIFO_MODE |-> RD_EMPTY) else $error("not empty");
    a_full_ram: assert property (@(posedge CORE_CLK) disable iff (SRST)
        !FIFO_MODE |-> !WR_FULL) else $error("full outside fifo");
    a_full_rst: assert property (@(posedge CORE_CLK)
        SRST ##1 SRST |-> !WR_FULL) else $error("full in reset");
    a_upper_zero: assert property (@(posedge RD_CLK) disable iff (SRST)
        RD_VALID && RD_MODE == bram_pkg::MODE_8192X9 |->
        RD_DATA[511:9] == '0) else $error("upper bits set");
endmodule

bind dual_clock_block_ram bram_chk i_chk (.CORE_CLK(CORE_CLK), .SRST(SRST),
    .RD_CLK(RD_CLK), .RD_MODE(RD_MODE), .FIFO_MODE(FIFO_MODE),
    .WR_FULL(WR_FULL), .RD_EN(RD_EN), .RD_DATA(RD_DATA),
    .RD_VALID(RD_VALID), .RD_EMPTY(RD_EMPTY));

/* sim/fabric_reader.sv */
`timescale 1ns/1ps
module fabric_reader (
    // read clock
    input wire logic rd_clk,
    // bench request
    input wire logic req,
    input wire logic [13:0] req_addr,
    // block read port
    output logic rd_en,
    output logic [13:0] rd_addr,
    input wire logic [511:0] rd_data,
    input wire logic rd_valid,
    input wire logic rd_empty,
    // captured results
    output logic [511:0] got_word,
    output int got_cnt,
    output logic empty_seen
);
    initial
    begin
        rd_en = 1'b0;
        rd_addr = 14'h0000;
        got_word = '0;
        got_cnt = 0;
        empty_seen = 1'b0;
    end

    // idle address toggles so a stale value is never trusted
    always @(posedge rd_clk)
    begin
        rd_en <= req;
        rd_addr <= req ? req_addr : ~rd_addr;
        empty_seen <= rd_empty;
        if (rd_valid)
        begin
            got_word <= rd_data;
            got_cnt <= got_cnt + 1;
        end
    end
endmodule

/* sim/tb_dual_clock_block_ram.sv */
`timescale 1ns/1ps
module tb_dual_clock_block_ram;
    logic core_clk, rd_clk, srst, rom_mode, fifo_mode, wr_en, wr_full;
    logic rd_en, rd_valid, rd_empty, req, empty_seen, got;
    logic [3:0] wr_mode, rd_mode;
    logic [13:0] wr_addr, rd_addr, req_addr;
    logic [511:0] wr_data, rd_data, got_word, word, exp_w;
    logic [511:0] fifo_q [0:128];
    int got_cnt, num_errors, comparisons, a;

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial
    begin
        rd_clk = 1'b0;
        #3.7;
        forever #6.5 rd_clk = ~rd_clk;
    end

    dual_clock_block_ram i_dut (.CORE_CLK(core_clk), .SRST(srst),
        .RD_CLK(rd_clk), .WR_MODE(wr_mode), .RD_MODE(rd_mode),
        .ROM_MODE(rom_mode), .FIFO_MODE(fifo_mode), .WR_EN(wr_en),
        .WR_ADDR(wr_addr), .WR_DATA(wr_data), .WR_FULL(wr_full),
        .RD_EN(rd_en), .RD_ADDR(rd_addr), .RD_DATA(rd_data),
        .RD_VALID(rd_valid), .RD_EMPTY(rd_empty));
    fabric_reader i_reader (.rd_clk(rd_clk), .req(req), .req_addr(req_addr),
        .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
        .rd_valid(rd_valid), .rd_empty(rd_empty), .got_word(got_word),
        .got_cnt(got_cnt), .empty_seen(empty_seen));

    // ----
    // expectations and bus tasks
    // ----
    function automatic int wid(input logic [3:0] m);
        int t [11] = '{144, 512, 72, 64, 36, 32, 18, 16, 9, 8, 4};
        return t[m];
    endfunction
    function automatic int dep(input logic [3:0] m);
        return ((wid(m) % 9 == 0) ? 73728 : 65536) / wid(m);
    endfunction
    function automatic logic [511:0] mask(input logic [3:0] m);
        return (512'h1 << wid(m)) - 512'h1;
    endfunction

    task automatic check(input string name, input logic [511:0] seen, exp);
        comparisons++;
        if (seen !== exp)
        begin
            $display("mismatch %s expected %h seen %h", name, exp, seen);
            num_errors++;
        end
    endtask

    task automatic do_reset(input logic [3:0] mw, mr, input logic rom, ff);
        @(posedge core_clk);
        srst <= 1'b1;
        wr_mode <= mw;
        rd_mode <= mr;
        rom_mode <= rom;
        fifo_mode <= ff;
        repeat (20) @(posedge core_clk);
        srst <= 1'b0;
        repeat (5) @(posedge rd_clk);
    endtask

    task automatic wr(input int adr, input logic [511:0] d);
        @(posedge core_clk);
        wr_en <= 1'b1;
        wr_addr <= adr[13:0];
        wr_data <= d;
        @(posedge core_clk);
        wr_en <= 1'b0;
        wr_data <= ~d;
    endtask

    task automatic rd(input int adr);
        int n;
        n = got_cnt;
        @(posedge rd_clk);
        req <= 1'b1;
        req_addr <= adr[13:0];
        @(posedge rd_clk);
        req <= 1'b0;
        for (int i = 0; i < 6 && got_cnt == n; i++) @(negedge rd_clk);
        got = (got_cnt != n);
        word = got_word;
    endtask

    task automatic close_out;
        if (num_errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        #500000;
        num_errors++;
        close_out;
    end

    initial
    begin
        {srst, rom_mode, fifo_mode, wr_en, req} = 5'h10;
        {wr_mode, rd_mode, wr_addr, req_addr} = '0;
        wr_data = '0;
        num_errors = 0;
        comparisons = 0;
        void'($urandom(32'h48BE21B4));
        for (int m = 0; m < 11; m++)
        begin
            do_reset(m[3:0], m[3:0], 1'b0, 1'b0);
            a = $urandom_range(dep(m[3:0]) - 2);
            exp_w = {16{$urandom}};
            wr(a, exp_w);
            wr(dep(m[3:0]) - 1, ~exp_w);
            rd(a);
            check("word", word, exp_w & mask(m[3:0]));
            rd(dep(m[3:0]) - 1);
            check("top word", word, ~exp_w & mask(m[3:0]));
            check("full in ram", {511'h0, wr_full}, 512'h0);
        end
        // nine-bit units written, read back as one 72-bit word
        do_reset(4'h8, 4'h2, 1'b0, 1'b0);
        a = $urandom_range(1023);
        exp_w = '0;
        for (int i = 0; i < 8; i++)
        begin
            word = {16{$urandom}};
            exp_w[9 * i +: 9] = word[8:0];
            wr(a * 8 + i, word);
        end
        rd(a);
        check("mixed", word, exp_w);
        do_reset(4'h2, 4'h2, 1'b1, 1'b0);
        wr(a, ~exp_w);
        rd(a);
        check("rom", word, exp_w);
        // codes past the last organization fall back to 512x144
        do_reset(4'hB, 4'hF, 1'b0, 1'b0);
        a = $urandom_range(510);
        exp_w = {16{$urandom}};
        wr(a, exp_w);
        rd(a);
        check("code fallback", word, exp_w & mask(4'h0));
        do_reset(4'h1, 4'h1, 1'b0, 1'b1);
        @(negedge rd_clk);
        check("empty at start", {511'h0, rd_empty}, 512'h1);
        rd(0);
        check("refused", {511'h0, got}, 512'h0);
        @(posedge core_clk);
        wr_en <= 1'b1;
        for (int i = 0; i < 129; i++)
        begin
            fifo_q[i] = {16{$urandom}};
            wr_data <= fifo_q[i];
            wr_addr <= ~wr_addr;
            @(posedge core_clk);
        end
        wr_en <= 1'b0;
        #1;
        check("full", {511'h0, wr_full}, 512'h1);
        for (int i = 0; i < 128; i++)
        begin
            rd(0);
            check("fifo word", word, fifo_q[i]);
        end
        rd(0);
        check("drained", {511'h0, got}, 512'h0);
        check("empty seen", {511'h0, empty_seen}, 512'h1);
        close_out;
    end
endmodule
